// ---- gdfs_pkg.sv ----
// Notes on behaviour
// - Supply-ok low 56 us on regulator excursion
// - Then hold supply-ok low until regulator valid
// - Warnings only report; gates untouched
// - Warning pulses fault pin 56 us low/high
// - Status read stops pulses; bit follows condition
// - No new pulses until condition clears, recurs
// - Fault: gates off, pin low, summary, type
// - Faults stay latched until recovery action
// - Fault overrides warning signalling on pin
// - Recover: cause gone, clear bit or enable pulse
// - Clear bit self-clears after fault released
// - Thermal flags live, never touch fault pin
// - Watchdog, regulator low go to supply-ok
// - Opposite gate waits for cutoff comparator
// - Dead time, minimum 40 ns, after handshake
// - Overcurrent threshold writable any time
// - Blank overcurrent after each commanded turn-on
// - Overcurrent must persist whole deglitch time
// - Dead and blanking timers run concurrently
// - Response mode: latched, report, disabled
// - Latched: all gates low, pin, record FET
// - Report: pin, record FET, gates keep running
// - Disabled: no action, no report
package gdfs_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int PULSE_TIME_NS = 56000;
  localparam int PULSE_CYCLES = PULSE_TIME_NS / CLK_PERIOD_NS;
  localparam int DEAD_MIN_NS = 40;
  localparam int DEAD_STEP_CYCLES = (DEAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_BASE_NS = 1000;
  localparam int BLANK_BASE_CYCLES = BLANK_BASE_NS / CLK_PERIOD_NS;
  localparam int DGL_BASE_NS = 500;
  localparam int DGL_BASE_CYCLES = DGL_BASE_NS / CLK_PERIOD_NS;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_STATUS = 4'h1;
  localparam logic [3:0] IDX_FAULT = 4'h2;
  localparam logic [3:0] IDX_VDS_FET = 4'h3;
  localparam logic [3:0] IDX_TIMING = 4'h7;
  localparam logic [3:0] IDX_CTRL = 4'h9;
  localparam logic [3:0] IDX_VDS_CFG = 4'hC;

  localparam int STAT_WARN_LSB = 0;
  localparam int STAT_VDSW_BIT = 4;
  localparam int STAT_THERM_LSB = 5;
  localparam int STAT_FAULT_BIT = 10;
  localparam int FLT_VDS_BIT = 4;
  localparam int FLT_WDOG_BIT = 5;
  localparam int FLT_REGLOW_BIT = 6;
  localparam int CTRL_CLR_BIT = 1;
  localparam int TIM_DEAD_LSB = 4;
  localparam int TIM_BLANK_LSB = 2;
  localparam int TIM_DGL_LSB = 0;
  localparam int VDS_LEVEL_LSB = 3;
  localparam int VDS_MODE_LSB = 0;

  localparam logic [6:0] TIMING_RST = 7'h00;
  localparam logic [7:0] VDS_CFG_RST = 8'h00;

  typedef enum logic [2:0] {
    VDS_LATCH = 3'b000,
    VDS_REPORT = 3'b001,
    VDS_OFF = 3'b010
  } gdfs_vds_mode_type;

  typedef enum logic [2:0] {
    PG_OK = 3'b001,
    PG_HOLD = 3'b010,
    PG_WAIT = 3'b100
  } gdfs_pg_state_type;
endpackage

// ---- gdfs_top.sv ----
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
module gdfs_top
  import gdfs_pkg::*;
#(
  parameter int PULSE_LEN = PULSE_CYCLES
) (
  input wire logic sys_clk, // Logic clock
  input wire logic rst, // Sync reset
  input wire logic [5:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic gate_enable, // Gate enable pin
  input wire logic [2:0] cmd_hi, // High-side commands
  input wire logic [2:0] cmd_lo, // Low-side commands
  input wire logic [5:0] vgs_off, // Gate below cutoff, lo<<3|hi
  input wire logic [5:0] vds_trip, // Overcurrent comparators
  input wire logic [3:0] warn_in, // Warning conditions
  input wire logic [3:0] fault_in, // Fault conditions
  input wire logic [3:0] temp_in, // Thermal flag conditions
  input wire logic regulator_in_window, // Regulator output valid
  input wire logic watchdog_fault, // Host watchdog expired
  input wire logic regulator_low_error, // Regulator undervoltage
  output logic [5:0] gate_out, // Gates, lo<<3|hi
  output logic [4:0] vds_level_out, // Overcurrent threshold
  output logic supply_ok_out, // Power good
  input wire logic fault_out_n_in, // Fault pin level
  output logic fault_out_n_out, // Fault pin drive value
  output logic fault_out_n_oe // Fault pin pulled low
);
  function automatic logic [6:0] dead_len(input logic [2:0] code);
    return 7'(DEAD_STEP_CYCLES * (int'(code) + 1));
  endfunction

  function automatic logic [11:0] blank_len(input logic [1:0] code);
    return 12'(BLANK_BASE_CYCLES << code);
  endfunction

  function automatic logic [11:0] dgl_len(input logic [1:0] code);
    return 12'(DGL_BASE_CYCLES << code);
  endfunction

  localparam logic [13:0] PULSE_LAST = 14'(PULSE_LEN - 1);

  logic ack_q;
  logic [31:0] rdata_q;
  logic [6:0] timing_q;
  logic [7:0] vds_cfg_q;
  logic clr_q;
  logic fault_q;
  logic [6:0] fault_type_q;
  logic [5:0] vds_fet_q;
  logic [4:0] report_q;
  logic [4:0] warn_prev_q;
  logic en_prev_q;
  logic [5:0] gate_q;
  logic [5:0] want_prev_q;
  logic [6:0] dt_cnt_q [6];
  logic [11:0] blank_cnt_q [6];
  logic [11:0] dg_cnt_q [6];
  logic [13:0] tog_cnt_q;
  logic tog_hi_q;
  logic pin_low_q;
  gdfs_pg_state_type pg_state_q;
  logic [13:0] pg_cnt_q;
  logic supply_ok_q;

  logic [3:0] idx;
  logic wr_en;
  logic rd_stat;
  logic [31:0] rd_mux;
  logic [5:0] cmd;
  logic [5:0] want;
  logic [5:0] vds_evt;
  logic vds_latch_evt;
  logic vds_rep_evt;
  logic [4:0] warn_cond;
  logic [4:0] warn_rise;
  logic en_rise;
  logic clear_go;
  logic pg_trig;
  gdfs_vds_mode_type vds_mode;

  assign idx = avs_address[5:2];
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr_en = ack_q & avs_write;
  assign rd_stat = ack_q & avs_read & (idx == IDX_STATUS);
  assign avs_readdata = rdata_q;
  assign vds_mode = gdfs_vds_mode_type'(vds_cfg_q[VDS_MODE_LSB +: 3]);
  assign vds_level_out = vds_cfg_q[VDS_LEVEL_LSB +: 5];
  assign gate_out = gate_q;
  assign supply_ok_out = supply_ok_q;
  assign fault_out_n_out = 1'b0;
  assign fault_out_n_oe = pin_low_q;

  // Bus slave: one wait cycle, data and write effect at the release edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (idx)
      IDX_STATUS: begin
        rd_mux[STAT_WARN_LSB +: 5] = warn_cond | report_q;
        rd_mux[STAT_THERM_LSB +: 4] = temp_in;
        rd_mux[STAT_FAULT_BIT] = fault_q;
      end
      IDX_FAULT: rd_mux[6:0] = fault_type_q;
      IDX_VDS_FET: rd_mux[5:0] = vds_fet_q;
      IDX_TIMING: rd_mux[6:0] = timing_q;
      IDX_CTRL: rd_mux[CTRL_CLR_BIT] = clr_q;
      IDX_VDS_CFG: rd_mux[7:0] = vds_cfg_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read & ~ack_q) begin
      rdata_q <= rd_mux;
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timing_q <= TIMING_RST;
      vds_cfg_q <= VDS_CFG_RST;
    end else if (wr_en) begin
      if (idx == IDX_TIMING) begin
        timing_q <= avs_writedata[6:0];
      end
      if (idx == IDX_VDS_CFG) begin
        vds_cfg_q <= avs_writedata[7:0];
      end
    end
  end

  // Clear bit drops once the fault has been released
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clr_q <= 1'b0;
    end else if (wr_en && idx == IDX_CTRL && avs_writedata[CTRL_CLR_BIT]) begin
      clr_q <= 1'b1;
    end else if (clr_q && !fault_q) begin
      clr_q <= 1'b0;
    end
  end

  // Fault latch and recovery
  assign en_rise = gate_enable & ~en_prev_q;
  assign clear_go = (clr_q | en_rise) & ~(|fault_in) & ~(|vds_trip);
  assign vds_latch_evt = (|vds_evt) & (vds_mode == VDS_LATCH);
  assign vds_rep_evt = (|vds_evt) & (vds_mode == VDS_REPORT);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      en_prev_q <= 1'b1;
      fault_q <= 1'b0;
      fault_type_q <= 7'h00;
      vds_fet_q <= 6'h00;
    end else begin
      en_prev_q <= gate_enable;
      if ((|fault_in) || vds_latch_evt) begin
        fault_q <= 1'b1;
      end else if (clear_go) begin
        fault_q <= 1'b0;
      end
      fault_type_q <= (clear_go ? 7'h00 : fault_type_q)
        | {regulator_low_error, watchdog_fault, vds_latch_evt, fault_in};
      vds_fet_q <= (clear_go ? 6'h00 : vds_fet_q)
        | (vds_latch_evt | vds_rep_evt ? vds_evt : 6'h00);
    end
  end

  // Warnings: edge-armed report, cleared by a status read
  assign warn_cond = {1'b0, warn_in};
  assign warn_rise = (warn_cond & ~warn_prev_q) | {vds_rep_evt, 4'h0};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      warn_prev_q <= 5'h00;
      report_q <= 5'h00;
    end else begin
      warn_prev_q <= warn_cond;
      report_q <= (report_q & ~{5{rd_stat}}) | warn_rise;
    end
  end

  // Fault pin: steady low on fault, toggling for pending warnings
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tog_cnt_q <= 14'h0000;
      tog_hi_q <= 1'b0;
      pin_low_q <= 1'b0;
    end else begin
      if (!(|report_q)) begin
        tog_cnt_q <= 14'h0000;
        tog_hi_q <= 1'b0;
      end else if (tog_cnt_q == PULSE_LAST) begin
        tog_cnt_q <= 14'h0000;
        tog_hi_q <= ~tog_hi_q;
      end else begin
        tog_cnt_q <= tog_cnt_q + 14'h0001;
      end
      pin_low_q <= fault_q | ((|report_q) & ~tog_hi_q);
    end
  end

  // Supply-ok sequencer
  assign pg_trig = ~regulator_in_window | watchdog_fault | regulator_low_error;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pg_state_q <= PG_OK;
      pg_cnt_q <= 14'h0000;
      supply_ok_q <= 1'b1;
    end else begin
      unique case (pg_state_q)
        PG_OK: begin
          pg_cnt_q <= 14'h0000;
          if (pg_trig) begin
            pg_state_q <= PG_HOLD;
            supply_ok_q <= 1'b0;
          end
        end
        PG_HOLD: begin
          pg_cnt_q <= pg_cnt_q + 14'h0001;
          if (pg_cnt_q == PULSE_LAST) begin
            pg_state_q <= PG_WAIT;
          end
        end
        PG_WAIT: begin
          if (!pg_trig) begin
            pg_state_q <= PG_OK;
            supply_ok_q <= 1'b1;
          end
        end
        default: begin
          pg_state_q <= PG_HOLD;
          supply_ok_q <= 1'b0;
        end
      endcase
    end
  end

  // Gate drive: handshake, dead time, blanking and deglitch per FET
  assign cmd = {cmd_lo, cmd_hi};

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      want[i] = cmd[i] & ~cmd[(i + 3) % 6] & gate_enable & ~fault_q;
      vds_evt[i] = gate_q[i] && blank_cnt_q[i] == 12'h000 && vds_trip[i]
        && dg_cnt_q[i] == dgl_len(timing_q[TIM_DGL_LSB +: 2]) - 12'h001
        && (vds_mode == VDS_LATCH || vds_mode == VDS_REPORT);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gate_q <= 6'h00;
      want_prev_q <= 6'h00;
      for (int i = 0; i < 6; i++) begin
        dt_cnt_q[i] <= 7'h00;
        blank_cnt_q[i] <= 12'h000;
        dg_cnt_q[i] <= 12'h000;
      end
    end else begin
      want_prev_q <= want;
      for (int i = 0; i < 6; i++) begin
        if (!want[i]) begin
          gate_q[i] <= 1'b0;
          dt_cnt_q[i] <= 7'h00;
        end else if (!gate_q[i]) begin
          if (!gate_q[(i + 3) % 6] && vgs_off[(i + 3) % 6]) begin
            if (dt_cnt_q[i] == dead_len(timing_q[TIM_DEAD_LSB +: 3]) - 7'h01) begin
              gate_q[i] <= 1'b1;
            end else begin
              dt_cnt_q[i] <= dt_cnt_q[i] + 7'h01;
            end
          end else begin
            dt_cnt_q[i] <= 7'h00;
          end
        end
        if (want[i] && !want_prev_q[i]) begin
          blank_cnt_q[i] <= blank_len(timing_q[TIM_BLANK_LSB +: 2]);
        end else if (blank_cnt_q[i] != 12'h000) begin
          blank_cnt_q[i] <= blank_cnt_q[i] - 12'h001;
        end
        if (!(gate_q[i] && blank_cnt_q[i] == 12'h000 && vds_trip[i])) begin
          dg_cnt_q[i] <= 12'h000;
        end else if (dg_cnt_q[i] != dgl_len(timing_q[TIM_DGL_LSB +: 2])) begin
          dg_cnt_q[i] <= dg_cnt_q[i] + 12'h001;
        end
      end
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic [13:0] low_run_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      low_run_q <= 14'h0000;
    end else if (supply_ok_q) begin
      low_run_q <= 14'h0000;
    end else if (low_run_q != 14'h3fff) begin
      low_run_q <= low_run_q + 14'h0001;
    end
  end

  sequence s_hs_fail;
    !gate_q[0] && !(!gate_q[3] && vgs_off[3]);
  endsequence

  sequence s_dead_min;
    !gate_q[0] [*8];
  endsequence

  AST_PG_MIN_LOW: assert property (
    $rose(supply_ok_out) |-> low_run_q >= PULSE_LAST)
    else $error("supply ok released before the low interval");
  AST_PG_RECHECK: assert property (
    (pg_state_q == PG_WAIT && pg_trig) |=> !supply_ok_out)
    else $error("supply ok released while regulator invalid");
  AST_FAULT_PIN: assert property (
    fault_q |=> fault_out_n_oe && gate_out == 6'h00)
    else $error("fault did not pull pin low and gates off");
  AST_FAULT_HOLD: assert property (
    (fault_q && !clear_go) |=> fault_q)
    else $error("fault released without recovery");
  AST_CLR_SELF: assert property (
    (clr_q && !fault_q && !wr_en) |=> !clr_q)
    else $error("clear bit did not self clear");
  AST_READ_CLEARS: assert property (
    (rd_stat && warn_rise == 5'h00) |=> report_q == 5'h00)
    else $error("status read did not stop warning report");
  AST_NO_REARM: assert property (
    (report_q == 5'h00 && warn_rise == 5'h00) |=> report_q == 5'h00)
    else $error("warning reported again without new edge");
  AST_DEAD_TIME: assert property (
    $rose(gate_q[0]) |-> $past(gate_q[3] == 1'b0 && vgs_off[3]))
    else $error("high side turned on without handshake");
  AST_DEAD_MIN: assert property (
    s_hs_fail |=> s_dead_min)
    else $error("dead time shorter than minimum");
  AST_DEAD_LEN: assert property (
    $rose(gate_q[0]) |-> $past(dt_cnt_q[0]) >= 7'(DEAD_STEP_CYCLES - 1))
    else $error("dead time below minimum count");
  AST_BLANK: assert property (
    blank_cnt_q[0] != 12'h000 |-> !vds_evt[0])
    else $error("overcurrent seen during blanking");
  AST_DEGLITCH: assert property (
    vds_evt[0] |-> $past(vds_trip[0], 1) && $past(vds_trip[0], 2))
    else $error("short overcurrent trip forwarded");
  AST_VDS_OFF: assert property (
    (vds_mode != VDS_LATCH && vds_mode != VDS_REPORT) |-> vds_evt == 6'h00)
    else $error("overcurrent acted on in disabled mode");
  AST_REPORT_RUNS: assert property (
    (vds_rep_evt && !(|fault_in)) |=> !fault_q || $past(fault_q))
    else $error("report mode shut the gates down");
endmodule

// ---- gdfs_host_model.sv ----
`timescale 1ns/1ps
module gdfs_host_model (
  input wire logic sys_clk, // Logic clock
  input wire logic fault_out_n_oe, // Device pulls pin low
  output logic fault_pin, // Pin level
  output int run, // Samples at current level
  output int low_run, // Last low phase length
  output int high_run // Last high phase length
);
  logic prev = 1'b1;
  initial run = 0;
  initial low_run = 0;
  initial high_run = 0;
  // Released pin rises through the pull-up
  assign fault_pin = fault_out_n_oe ? 1'b0 : 1'b1;
  always @(posedge sys_clk) begin
    prev <= fault_pin;
    run <= (fault_pin == prev) ? run + 1 : 1;
    if (fault_pin != prev && prev) high_run <= run;
    if (fault_pin != prev && !prev) low_run <= run;
  end
endmodule

// ---- gdfs_top_tb.sv ----
`timescale 1ns/1ps
`define PE @(posedge sys_clk)
`define NE @(negedge sys_clk)
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fail_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module gdfs_top_tb
  import gdfs_pkg::*;
;
  localparam int P = 16;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic gate_enable = 1'b1;
  logic [2:0] cmd_hi = '0;
  logic [2:0] cmd_lo = '0;
  logic [5:0] vgs_off = 6'h3F;
  logic [5:0] vds_trip = '0;
  logic [3:0] warn_in = '0;
  logic [3:0] fault_in = '0;
  logic [3:0] temp_in = '0;
  logic regulator_in_window = 1'b1;
  logic watchdog_fault = 1'b0;
  logic regulator_low_error = 1'b0;
  logic [5:0] gate_out;
  logic [4:0] vds_level_out;
  logic supply_ok_out;
  logic fault_out_n_oe;
  logic fault_pin;
  int run;
  int low_run;
  int high_run;
  int fail_count = 0;
  int n_tests = 0;
  int n;
  logic [31:0] r;

  always #2.5 sys_clk = ~sys_clk;

  gdfs_top #(.PULSE_LEN(P)) i_dut (.sys_clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .gate_enable, .cmd_hi, .cmd_lo,
    .vgs_off, .vds_trip, .warn_in, .fault_in, .temp_in, .regulator_in_window,
    .watchdog_fault, .regulator_low_error, .gate_out, .vds_level_out, .supply_ok_out,
    .fault_out_n_in(fault_pin), .fault_out_n_out(), .fault_out_n_oe);
  gdfs_host_model i_host (.sys_clk, .fault_out_n_oe, .fault_pin, .run, .low_run, .high_run);

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic hang();
    fail_count++;
    $display("CHECK FAILED wait expected done seen timeout");
    end_of_test();
  endtask

  // One Avalon transfer; read data lands in r
  task automatic bus(input logic wr_en, input logic [3:0] idx, input logic [31:0] wd);
    int k;
    k = 0;
    `PE;
    avs_address <= {idx, 2'b00};
    avs_write <= wr_en;
    avs_read <= ~wr_en;
    avs_writedata <= wd;
    do begin
      `PE;
      if (++k > 20) hang();
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] idx);
    bus(1'b0, idx, 32'h0000_0000);
  endtask

  task automatic wait_oe(input logic v);
    int k;
    k = 0;
    do begin
      `NE;
      if (++k > 500) hang();
    end while (fault_out_n_oe !== v);
  endtask

  task automatic meas(output int c);
    c = 0;
    do begin
      `NE;
      if (++c > 500) hang();
    end while (gate_out[0] !== 1'b1);
  endtask

  initial begin
    repeat (2) `PE;
    rst <= 1'b0;
    `NE;
    `CHK("reset", 13'h0040, {gate_out, supply_ok_out, fault_out_n_oe, vds_level_out})
    rd(IDX_TIMING);
    `CHK("timing", TIMING_RST, r[6:0])
    rd(IDX_VDS_CFG);
    `CHK("vds cfg", VDS_CFG_RST, r[7:0])
    bus(1'b1, 4'hF, 32'hFFFF_FFFF);
    rd(4'hF);
    `CHK("unmapped", 32'h0000_0000, r)
    `PE;
    regulator_in_window <= 1'b0;
    `PE;
    regulator_in_window <= 1'b1;
    repeat (P - 3) `PE;
    `NE;
    `CHK("pg pulse", 1'b0, supply_ok_out)
    repeat (6) `PE;
    `NE;
    `CHK("pg end", 1'b1, supply_ok_out)
    `PE;
    regulator_in_window <= 1'b0;
    repeat (P + 8) `PE;
    `NE;
    `CHK("pg hold", 1'b0, supply_ok_out)
    `PE;
    regulator_in_window <= 1'b1;
    repeat (4) `PE;
    `NE;
    `CHK("pg back", 1'b1, supply_ok_out)
    for (int i = 0; i < 2; i++) begin
      `PE;
      watchdog_fault <= (i == 0);
      regulator_low_error <= (i == 1);
      repeat (3) `PE;
      watchdog_fault <= 1'b0;
      regulator_low_error <= 1'b0;
      `NE;
      `CHK("pg event", 2'b00, {supply_ok_out, fault_out_n_oe})
      repeat (P + 6) `PE;
    end
    rd(IDX_FAULT);
    `CHK("sticky", 2'b11, r[6:5])
    for (int c = 0; c < 8; c++) begin
      `PE;
      cmd_hi <= 3'h0;
      bus(1'b1, IDX_TIMING, 32'(c) << 4);
      vgs_off <= (c == 0) ? 6'h37 : 6'h3F;
      cmd_hi <= 3'h1;
      if (c == 0) begin
        repeat (40) `PE;
        `NE;
        `CHK("handshake", 6'h00, gate_out)
        `PE;
        vgs_off <= 6'h3F;
      end
      meas(n);
      `CHK("dead", 1'b1, n inside {[DEAD_STEP_CYCLES * (c + 1) + 1 : DEAD_STEP_CYCLES * (c + 1) + 5]})
    end
    `PE;
    warn_in <= 4'h1;
    wait_oe(1'b1);
    wait_oe(1'b0);
    wait_oe(1'b1);
    repeat (2) `PE;
    `NE;
    `CHK("low", P, low_run)
    `CHK("high", P, high_run)
    `CHK("warn gates", 6'h01, gate_out)
    rd(IDX_STATUS);
    `CHK("warn", 1'b1, r[STAT_WARN_LSB])
    repeat (3 * P) `PE;
    `NE;
    `CHK("quiet", 1'b1, fault_pin === 1'b1 && run > 2 * P)
    rd(IDX_STATUS);
    `CHK("warn held", 1'b1, r[STAT_WARN_LSB])
    warn_in <= 4'h0;
    repeat (2) `PE;
    rd(IDX_STATUS);
    `CHK("warn gone", 1'b0, r[STAT_WARN_LSB])
    warn_in <= 4'h1;
    wait_oe(1'b1);
    `PE;
    fault_in <= 4'h2;
    repeat (3 * P) `PE;
    `NE;
    `CHK("fault pin", 7'h40, {fault_out_n_oe, gate_out})
    rd(IDX_STATUS);
    `CHK("summary", 1'b1, r[STAT_FAULT_BIT])
    rd(IDX_FAULT);
    `CHK("type", 1'b1, r[1])
    fault_in <= 4'h0;
    warn_in <= 4'h0;
    repeat (2 * P) `PE;
    rd(IDX_STATUS);
    `NE;
    `CHK("latched", 7'h40, {fault_out_n_oe, gate_out})
    bus(1'b1, IDX_CTRL, 32'h0000_0002);
    repeat (3) `PE;
    rd(IDX_CTRL);
    `CHK("clear bit", 1'b0, r[CTRL_CLR_BIT])
    rd(IDX_STATUS);
    `CHK("released", 2'b00, {fault_out_n_oe, r[STAT_FAULT_BIT]})
    rd(IDX_FAULT);
    `CHK("types", 7'h00, r[6:0])
    fault_in <= 4'h1;
    repeat (5) `PE;
    fault_in <= 4'h0;
    gate_enable <= 1'b0;
    `PE;
    gate_enable <= 1'b1;
    repeat (4) `PE;
    `NE;
    `CHK("enable pulse", 1'b0, fault_out_n_oe)
    `PE;
    temp_in <= 4'hA;
    rd(IDX_STATUS);
    `CHK("thermal", 5'h0A, {fault_out_n_oe, r[8:5]})
    temp_in <= 4'h0;
    repeat (2) `PE;
    rd(IDX_STATUS);
    `CHK("thermal live", 4'h0, r[8:5])
    for (int m = 0; m < 3; m++) begin
      `PE;
      cmd_hi <= 3'h0;
      repeat (4) `PE;
      // Blank and deglitch codes follow m; dead code stays at 7
      bus(1'b1, IDX_TIMING, 32'h0000_0070 | 32'(m << 2) | 32'(m));
      cmd_hi <= 3'h1;
      bus(1'b1, IDX_VDS_CFG, 32'h0000_00A8 | 32'(m));
      `NE;
      `CHK("level", 5'h15, vds_level_out)
      repeat (25) `PE;
      vds_trip <= 6'h01;
      repeat ((BLANK_BASE_CYCLES << m) - 50) `PE;
      vds_trip <= 6'h00;
      `NE;
      `CHK("blank", 1'b0, fault_out_n_oe)
      repeat (30) `PE;
      vds_trip <= 6'h01;
      repeat ((DGL_BASE_CYCLES << m) - 10) `PE;
      `NE;
      `CHK("deglitch", 1'b0, fault_out_n_oe)
      repeat (25) `PE;
      `NE;
      `CHK("vds gates", (m == 0) ? 6'h00 : 6'h01, gate_out)
      if (m < 2) wait_oe(1'b1);
      rd(IDX_VDS_FET);
      `CHK("fet", m < 2, r[0])
      rd(IDX_STATUS);
      `CHK("vds warn", m == 1, r[STAT_VDSW_BIT])
      rd(IDX_FAULT);
      `CHK("vds fault", m == 0, r[FLT_VDS_BIT])
      `NE;
      if (m == 2) `CHK("off", 1'b1, fault_pin === 1'b1 && run > 2 * P)
      `PE;
      vds_trip <= 6'h00;
      if (m == 1) begin
        repeat (5) `PE;
        vds_trip <= 6'h01;
        repeat (50) `PE;
        vds_trip <= 6'h00;
        repeat (P) `PE;
        `NE;
        `CHK("short trip", 1'b1, fault_pin === 1'b1 && run > 60)
        `PE;
      end
      cmd_hi <= 3'h0;
      bus(1'b1, IDX_CTRL, 32'h0000_0002);
    end
    end_of_test();
  end
endmodule
